// ==== src/qio_pkg.sv ====
// package: constants, types and address decode for the quasi-bidirectional i/o expander
package qio_pkg;

    // four-state address pin codes: rail pins carry bit1 = 0, bus-tied pins bit1 = 1
    localparam logic [1:0] PIN_VSS   = 2'h0;
    localparam logic [1:0] PIN_VDD   = 2'h1;
    localparam logic [1:0] PIN_SCL   = 2'h2;
    localparam logic [1:0] PIN_SDA   = 2'h3;

    localparam logic [6:0] GC_ADDR   = 7'h00;
    localparam logic [6:0] ID_ADDR   = 7'h7c;
    localparam logic [7:0] SWRST_CMD = 8'h06;
    localparam logic [7:0] LATCH_RST = 8'hff;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_CNT   = 4'h8;
    localparam logic [1:0] ID_LAST   = 2'h2;

    // identification bytes: values are arbitrary
    localparam logic [7:0] ID_MFR    = 8'h5a;
    localparam logic [7:0] ID_PART   = 8'h3c;
    localparam logic [7:0] ID_REV    = 8'h01;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACKW, ST_ACK, ST_WDATA,
        ST_RDATA, ST_RACK, ST_RNEXT, ST_IGNORE
    } qio_state_e;

    typedef enum logic [1:0] {K_NONE, K_PORT, K_GC, K_ID} qio_kind_e;

    typedef struct packed {
        qio_state_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic       rw;
        qio_kind_e  kind;
        logic       ackNow;
        logic       drvLow;
        logic [7:0] latch;
        logic [7:0] lastRead;
        logic       intPend;
        logic       rstPend;
        logic       idArmed;
        logic       moreByte;
        logic [1:0] idIdx;
        logic [5:0] adSync1;
        logic [5:0] adSync2;
        logic [7:0] pinSync1;
        logic [7:0] pinSync2;
    } qio_core_s;

    localparam qio_core_s CORE_RST = '{
        st: ST_IDLE, cnt: 4'h0, sh: 8'h00, rw: 1'b0, kind: K_NONE, ackNow: 1'b0,
        drvLow: 1'b0, latch: LATCH_RST, lastRead: 8'hff, intPend: 1'b0,
        rstPend: 1'b0, idArmed: 1'b0, moreByte: 1'b0, idIdx: 2'h0,
        adSync1: 6'h00, adSync2: 6'h00, pinSync1: 8'hff, pinSync2: 8'hff};

    typedef struct packed {
        logic sclS1;
        logic sclS2;
        logic sclS3;
        logic sdaS1;
        logic sdaS2;
        logic sdaS3;
    } qio_front_s;

    localparam qio_front_s FRONT_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

    // seven-bit slave address from the three pin codes
    function automatic logic [6:0] qio_decode(input logic varA, input logic [1:0] p2,
                                              input logic [1:0] p1, input logic [1:0] p0);
        logic [2:0] onBus;
        logic [3:0] pre;
        onBus = {p2[1], p1[1], p0[1]};
        case (onBus)
            3'h0: pre = varA ? 4'h7 : 4'h4;
            3'h1: pre = varA ? 4'h8 : 4'h5;
            3'h2: pre = varA ? 4'h1 : 4'h2;
            3'h3: pre = varA ? 4'h6 : 4'h3;
            3'h4: pre = varA ? 4'hf : 4'hc;
            3'h5: pre = varA ? 4'h0 : 4'he;
            3'h6: pre = varA ? 4'h9 : 4'ha;
            default: pre = varA ? 4'hd : 4'hb;
        endcase
        return {pre, p2[0], p1[0], p0[0]};
    endfunction

    function automatic logic [7:0] qio_id_byte(input logic [1:0] idx);
        case (idx)
            2'h0: return ID_MFR;
            2'h1: return ID_PART;
            default: return ID_REV;
        endcase
    endfunction

endpackage

// ==== src/qio_bus_if.sv ====
// interface: bus conditions from the line front end to the expander core
`timescale 1ns/100ps
interface qio_bus_if;
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
    logic sdaBit;
    modport front (output sclRise, sclFall, start, stop, sdaBit);
    modport core  (input  sclRise, sclFall, start, stop, sdaBit);
endinterface

// ==== src/qio_bus_front.sv ====
// module: synchronises the two bus lines and finds edges, start and stop
`timescale 1ns/100ps
module qio_bus_front (
    // clock and reset
    input  logic   sys_clk,
    input  logic   sys_rst,
    // bus lines
    input  logic   sclIn,
    input  logic   sdaIn,
    // conditions
    qio_bus_if.front bus
);
    import qio_pkg::*;

    qio_front_s r;
    qio_front_s n;

    always_comb begin
        n       = r;
        n.sclS1 = sclIn;
        n.sclS2 = r.sclS1;
        n.sclS3 = r.sclS2;
        n.sdaS1 = sdaIn;
        n.sdaS2 = r.sdaS1;
        n.sdaS3 = r.sdaS2;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r <= FRONT_RST;
        end else begin
            r <= n;
        end
    end

    // stage 1 is seen only by stage 2; all decisions use stages 2 and 3
    assign bus.sdaBit  = r.sdaS2;
    assign bus.sclRise = r.sclS2 && !r.sclS3;
    assign bus.sclFall = !r.sclS2 && r.sclS3;
    assign bus.start   = r.sclS2 && r.sclS3 && r.sdaS3 && !r.sdaS2;
    assign bus.stop    = r.sclS2 && r.sclS3 && !r.sdaS3 && r.sdaS2;
endmodule

// ==== src/qio_expander.sv ====
// module: two-wire slave front end of an 8-line quasi-bidirectional i/o expander
`timescale 1ns/100ps
module qio_expander #(
    parameter bit VARIANT_A = 1'b0
) (
    // clock and reset
    input  logic       sys_clk,
    input  logic       sys_rst,
    // serial bus
    input  logic       sclIn,
    input  logic       sdaIn,
    output logic       sdaOut,
    output logic       sdaEnN,
    // address select straps, qio_pkg::PIN_VSS .. qio_pkg::PIN_SDA
    input  logic [1:0] addrSelectPin0,
    input  logic [1:0] addrSelectPin1,
    input  logic [1:0] addrSelectPin2,
    // port lines io_line_0 .. io_line_7
    input  logic [7:0] ioLineIn,
    output logic [7:0] ioLineOut,
    output logic [7:0] ioLineEnN,
    // interrupt
    output logic       intOut,
    output logic       intEnN
);
    import qio_pkg::*;

    qio_bus_if bus ();

    qio_bus_front uFront (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .sclIn   (sclIn),
        .sdaIn   (sdaIn),
        .bus     (bus)
    );

    qio_core_s  r;
    qio_core_s  n;
    logic [6:0] myAddr;
    logic       reservedHit;
    logic [7:0] rxByte;
    logic       byteDone;
    logic       portClr;
    logic [1:0] idNext;

    assign myAddr      = qio_decode(VARIANT_A, r.adSync2[5:4], r.adSync2[3:2],
                                    r.adSync2[1:0]);
    assign reservedHit = VARIANT_A && (myAddr == GC_ADDR || myAddr == ID_ADDR);
    assign rxByte      = {r.sh[6:0], bus.sdaBit};
    assign byteDone    = bus.sclRise && r.cnt == BIT_LAST
                         && (r.st == ST_ADDR || r.st == ST_WDATA);
    assign idNext      = (r.idIdx == ID_LAST) ? 2'h0 : r.idIdx + 2'h1;

    always_comb begin
        n          = r;
        portClr    = 1'b0;
        // straps and port inputs come from outside: two flops before use
        n.adSync1  = {addrSelectPin2, addrSelectPin1, addrSelectPin0};
        n.adSync2  = r.adSync1;
        n.pinSync1 = ioLineIn;
        n.pinSync2 = r.pinSync1;
        if (bus.start) begin
            n.st       = ST_ADDR;
            n.cnt      = 4'h0;
            n.drvLow   = 1'b0;
            n.rstPend  = 1'b0;
            n.moreByte = 1'b0;
        end else if (bus.stop) begin
            if (r.rstPend) begin
                n.latch   = LATCH_RST;
                n.rstPend = 1'b0;
                n.idArmed = 1'b0;
                portClr   = 1'b1;
            end
            n.st     = ST_IDLE;
            n.drvLow = 1'b0;
        end else begin
            case (r.st)
                ST_ADDR, ST_WDATA: begin
                    if (bus.sclRise) begin
                        n.sh  = rxByte;
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (byteDone) begin
                        n.st     = ST_ACKW;
                        n.cnt    = 4'h0;
                        n.ackNow = 1'b0;
                        if (r.st == ST_ADDR) begin
                            n.rw   = rxByte[0];
                            n.kind = K_NONE;
                            if (rxByte[7:1] == myAddr && !reservedHit) begin
                                n.kind   = K_PORT;
                                n.ackNow = 1'b1;
                                if (rxByte[0]) begin
                                    n.sh     = r.pinSync2;
                                    n.lastRead = r.pinSync2;
                                    portClr  = 1'b1;
                                end
                            end else if (rxByte[7:1] == GC_ADDR) begin
                                if (!rxByte[0]) begin
                                    n.kind   = K_GC;
                                    n.ackNow = 1'b1;
                                end
                            end else if (rxByte[7:1] == ID_ADDR) begin
                                if (!rxByte[0]) begin
                                    n.kind    = K_ID;
                                    n.ackNow  = 1'b1;
                                    n.idArmed = 1'b0;
                                end else if (r.idArmed) begin
                                    n.kind    = K_ID;
                                    n.ackNow  = 1'b1;
                                    n.idIdx   = 2'h0;
                                    n.sh      = qio_id_byte(2'h0);
                                    n.idArmed = 1'b0;
                                end
                            end
                        end else begin
                            n.moreByte = 1'b1;
                            case (r.kind)
                                K_PORT: begin
                                    n.latch    = rxByte;
                                    n.lastRead = r.pinSync2;
                                    n.ackNow   = 1'b1;
                                    portClr    = 1'b1;
                                end
                                K_GC: begin
                                    // one command byte only; anything else aborts
                                    n.ackNow  = !r.moreByte && rxByte == SWRST_CMD;
                                    n.rstPend = !r.moreByte && rxByte == SWRST_CMD;
                                end
                                K_ID: begin
                                    if (!r.moreByte && rxByte[7:1] == myAddr && !reservedHit) begin
                                        n.idArmed = 1'b1;
                                        n.ackNow  = 1'b1;
                                    end
                                end
                                default: n.ackNow = 1'b0;
                            endcase
                        end
                    end
                end
                ST_ACKW: begin
                    if (bus.sclFall) begin
                        n.drvLow = r.ackNow;
                        n.st     = ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (bus.sclFall) begin
                        n.drvLow = 1'b0;
                        n.cnt    = 4'h0;
                        if (!r.ackNow) begin
                            n.st = ST_IGNORE;
                        end else if (r.rw) begin
                            n.st     = ST_RDATA;
                            n.drvLow = !r.sh[7];
                        end else begin
                            n.st = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (bus.sclRise) begin
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (bus.sclFall) begin
                        if (r.cnt == BIT_CNT) begin
                            n.drvLow = 1'b0;
                            n.st     = ST_RACK;
                        end else begin
                            n.sh     = {r.sh[6:0], 1'b0};
                            n.drvLow = !r.sh[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (bus.sclRise) begin
                        if (!bus.sdaBit) begin
                            n.st = ST_RNEXT;
                            if (r.kind == K_PORT) begin
                                n.sh       = r.pinSync2;
                                n.lastRead = r.pinSync2;
                                portClr    = 1'b1;
                            end else begin
                                n.idIdx = idNext;
                                n.sh    = qio_id_byte(idNext);
                            end
                        end else begin
                            n.st = ST_IGNORE;
                        end
                    end
                end
                ST_RNEXT: begin
                    if (bus.sclFall) begin
                        n.drvLow = !r.sh[7];
                        n.cnt    = 4'h0;
                        n.st     = ST_RDATA;
                    end
                end
                default: n.st = r.st;
            endcase
        end
        // a read rebases the compare value, so a change in that cycle is in the data read
        if (portClr) begin
            n.intPend = 1'b0;
            if (bus.stop) begin
                n.lastRead = r.pinSync2;
            end
        end else begin
            n.intPend = r.intPend || (r.pinSync2 != r.lastRead);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r <= CORE_RST;
        end else begin
            r <= n;
        end
    end

    // open-drain style: only ever pull low; released lines are inputs
    assign sdaOut    = 1'b0;
    assign sdaEnN    = !r.drvLow;
    assign ioLineOut = 8'h00;
    assign ioLineEnN = r.latch;
    assign intOut    = 1'b0;
    assign intEnN    = !r.intPend;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_cmd_taken;
        byteDone && r.st == ST_WDATA && r.kind == K_GC && !r.moreByte && rxByte == SWRST_CMD;
    endsequence
    sequence s_cmd_acked;
        r.st == ST_ACKW && r.ackNow && r.rstPend;
    endsequence

    a_dir_bit: assert property (
        (byteDone && r.st == ST_ADDR) |=> (r.st == ST_ACKW && r.rw == $past(bus.sdaBit)))
        else $error("direction bit not captured");
    a_addr_pins: assert property (
        (r.adSync2 == {PIN_SCL, PIN_SCL, PIN_SDA}) |-> myAddr == (VARIANT_A ? 7'h69 : 7'h59))
        else $error("pin code decoded to wrong address");
    a_reserved_nack: assert property (
        (byteDone && r.st == ST_ADDR && reservedHit && rxByte[7:1] == myAddr)
        |=> r.kind != K_PORT)
        else $error("reserved own address was taken");
    a_legacy_rails: assert property (
        (r.adSync2[5] == 1'b0 && r.adSync2[3] == 1'b0 && r.adSync2[1] == 1'b0)
        |-> myAddr == {(VARIANT_A ? 4'h7 : 4'h4), r.adSync2[4], r.adSync2[2], r.adSync2[0]})
        else $error("rail straps do not give legacy address");
    a_port_reset: assert property (
        (bus.stop && r.rstPend) |=> (ioLineEnN == LATCH_RST && r.st == ST_IDLE))
        else $error("software reset left port driven");
    a_int_assert: assert property (
        (r.st == ST_IDLE && !bus.start && !bus.stop && r.pinSync2 != r.lastRead)
        |=> !intEnN)
        else $error("input change did not pull interrupt");
    a_latch_hold: assert property (
        !(byteDone && r.st == ST_WDATA && r.kind == K_PORT) && !(bus.stop && r.rstPend)
        |=> $stable(r.latch))
        else $error("output latch changed without a write");
    a_id_first: assert property (
        (byteDone && r.st == ST_ADDR && rxByte == {ID_ADDR, 1'b1} && r.idArmed)
        |=> (r.sh == ID_MFR && r.kind == K_ID))
        else $error("identification read did not load first byte");
    a_reset_cmd: assert property (
        s_cmd_taken |=> s_cmd_acked)
        else $error("reset command not acknowledged");
    a_restart_cancel: assert property (
        bus.start |=> !r.rstPend)
        else $error("repeated start did not cancel reset");
    a_gc_read_nack: assert property (
        (byteDone && r.st == ST_ADDR && rxByte == {GC_ADDR, 1'b1}) |=> !r.ackNow)
        else $error("general call read acknowledged");
    a_gc_extra_nack: assert property (
        (byteDone && r.st == ST_WDATA && r.kind == K_GC && r.moreByte)
        |=> (!r.ackNow && !r.rstPend))
        else $error("extra reset byte acknowledged");
    a_int_release: assert property (
        (r.st == ST_RACK && bus.sclRise && !bus.sdaBit && r.kind == K_PORT && !bus.stop)
        |=> intEnN)
        else $error("port read did not release interrupt");
endmodule

// ==== verif/qio_bus_master.sv ====
// partner: two-wire bus master model driving clock and data open-drain
`timescale 1ns/100ps
module qio_bus_master #(
    parameter int QTR_NS = 50
) (
    // resolved data line
    input  logic sdaIn,
    // open-drain drives, high pulls the line low
    output logic sclLow,
    output logic sdaLow
);
    // quarter of the 200 ns bus clock; every step lands just after a sys_clk edge
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end

    // start or repeated start; clock stands high between frames
    task automatic bus_start();
        sdaLow = 1'b0;
        // half a period: a slave's ack must be gone before scl rises, else a stop is seen
        #(2*QTR_NS);
        sclLow = 1'b0;
        #(2*QTR_NS);
        sdaLow = 1'b1;
        #(2*QTR_NS);
        sclLow = 1'b1;
    endtask

    // data changes only mid low phase, sampled at end of high phase
    task automatic bus_bit(input logic b, output logic seen);
        #(QTR_NS);
        sdaLow = ~b;
        #(QTR_NS);
        sclLow = 1'b0;
        #(2*QTR_NS);
        seen = sdaIn;
        sclLow = 1'b1;
    endtask

    // msb first, then ninth clock for the acknowledge
    task automatic bus_byte(input logic [7:0] tx, input logic ackIt,
                            output logic [7:0] rx, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(tx[i], s);
            rx[i] = s;
        end
        bus_bit(~ackIt, s);
        acked = ~s;
    endtask

    task automatic bus_stop();
        #(QTR_NS);
        sdaLow = 1'b1;
        #(QTR_NS);
        sclLow = 1'b0;
        #(2*QTR_NS);
        sdaLow = 1'b0;
        #(2*QTR_NS);
    endtask
endmodule

// ==== verif/quasi_io_expander_bus_address_test.sv ====
// testbench: expander slave front end against a bus master model
`timescale 1ns/100ps
module quasi_io_expander_bus_address_test;
    import qio_pkg::*;
    // {ad2, ad1, ad0, 8-bit address}; neighbours avoid reserved codes
    localparam logic [13:0] TAB_B [4] = '{{PIN_VSS, PIN_SCL, PIN_VSS, 8'h20},
        {PIN_SDA, PIN_SDA, PIN_SDA, 8'hbe}, {PIN_VDD, PIN_SDA, PIN_SCL, 8'h3c},
        {PIN_VSS, PIN_VSS, PIN_VSS, 8'h40}};
    localparam logic [14:0] TAB_A [4] = '{{PIN_VSS, PIN_VSS, PIN_VSS, 8'h70, 1'b1},
        {PIN_SDA, PIN_VSS, PIN_VDD, 8'hfa, 1'b1}, {PIN_SDA, PIN_VSS, PIN_VSS, 8'hf9, 1'b0},
        {PIN_SCL, PIN_SCL, PIN_SDA, 8'hd2, 1'b1}};
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       mSclLow, mSdaLow, sdaEnN, sdaEnNA, intEnN, lastA;
    logic [5:0] strapB = '0;
    logic [5:0] strapA = '0;
    logic [7:0] extLow = 8'h00;
    logic [7:0] ioEnN;
    logic       sclWire, sdaWire;
    int         mismatches = 0;
    int         compares = 0;

    // pull-ups on both bus lines; second device kept off the wire
    assign sclWire = ~mSclLow;
    assign sdaWire = ~(mSdaLow | ~sdaEnN);
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sclWire) lastA <= ~sdaEnNA;

    qio_expander i_qio_expander (.sys_clk(sys_clk), .sys_rst(sys_rst), .sclIn(sclWire),
        .sdaIn(sdaWire), .sdaOut(), .sdaEnN(sdaEnN), .addrSelectPin0(strapB[1:0]),
        .addrSelectPin1(strapB[3:2]), .addrSelectPin2(strapB[5:4]),
        .ioLineIn(ioEnN & ~extLow), .ioLineOut(), .ioLineEnN(ioEnN), .intOut(), .intEnN(intEnN));
    qio_expander #(.VARIANT_A(1'b1)) i_qio_expander_a (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .sclIn(sclWire), .sdaIn(sdaWire), .sdaOut(), .sdaEnN(sdaEnNA),
        .addrSelectPin0(strapA[1:0]), .addrSelectPin1(strapA[3:2]),
        .addrSelectPin2(strapA[5:4]), .ioLineIn(8'hff), .ioLineOut(), .ioLineEnN(), .intOut(),
        .intEnN());
    qio_bus_master i_qio_bus_master (.sdaIn(sdaWire), .sclLow(mSclLow), .sdaLow(mSdaLow));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic send(input logic [7:0] b, input logic expAck);
        logic [7:0] rx;
        logic       a;
        i_qio_bus_master.bus_byte(b, 1'b0, rx, a);
        check("ack", {7'h0, a}, {7'h0, expAck});
    endtask

    task automatic recv(input logic ackIt, input logic [7:0] exp);
        logic [7:0] rx;
        logic       a;
        i_qio_bus_master.bus_byte(8'hff, ackIt, rx, a);
        check("read data", rx, exp);
    endtask

    task automatic t_address();
        foreach (TAB_B[k]) begin
            strapB = TAB_B[k][13:8];
            tick(4);
            i_qio_bus_master.bus_start();
            send(TAB_B[k][7:0], 1'b1);
            i_qio_bus_master.bus_start();
            send(TAB_B[k][7:0] ^ 8'h02, 1'b0);
            i_qio_bus_master.bus_stop();
        end
        foreach (TAB_A[k]) begin
            strapA = TAB_A[k][14:9];
            tick(4);
            i_qio_bus_master.bus_start();
            send(TAB_A[k][8:1], 1'b0);
            check("variant ack", {7'h0, lastA}, {7'h0, TAB_A[k][0]});
            i_qio_bus_master.bus_stop();
        end
    endtask

    task automatic t_write_read();
        i_qio_bus_master.bus_start();
        send(8'h40, 1'b1);
        send(8'h5a, 1'b1);
        check("latch", ioEnN, 8'h5a);
        send(8'ha5, 1'b1);
        i_qio_bus_master.bus_stop();
        tick(20);
        check("latch held", ioEnN, 8'ha5);
        i_qio_bus_master.bus_start();
        send(8'h40, 1'b1);
        send(8'hff, 1'b1);
        i_qio_bus_master.bus_stop();
        // own writes move the pins; a read rebases the compare value first
        i_qio_bus_master.bus_start();
        send(8'h41, 1'b1);
        recv(1'b0, 8'hff);
        i_qio_bus_master.bus_stop();
        tick(2);
        check("interrupt idle", {7'h0, intEnN}, 8'h01);
        extLow = 8'h0f;
        for (int k = 0; k < 10 && intEnN !== 1'b0; k++) tick(1);
        check("interrupt set", {7'h0, intEnN}, 8'h00);
        i_qio_bus_master.bus_start();
        send(8'h41, 1'b1);
        recv(1'b1, 8'hf0);
        recv(1'b0, 8'hf0);
        i_qio_bus_master.bus_stop();
        check("interrupt clear", {7'h0, intEnN}, 8'h01);
        extLow = 8'h00;
    endtask

    // mode 1 adds a second command byte, mode 2 a repeated start before stop
    task automatic soft_reset(input logic [7:0] cmd, input int mode, input logic expAck,
                              input logic [7:0] expLatch);
        i_qio_bus_master.bus_start();
        send(8'h40, 1'b1);
        send(8'h00, 1'b1);
        i_qio_bus_master.bus_stop();
        i_qio_bus_master.bus_start();
        send({GC_ADDR, 1'b0}, 1'b1);
        send(cmd, expAck);
        if (mode == 1) send(SWRST_CMD, 1'b0);
        if (mode == 2) i_qio_bus_master.bus_start();
        i_qio_bus_master.bus_stop();
        tick(4);
        check("latch after reset", ioEnN, expLatch);
    endtask

    task automatic t_ident();
        i_qio_bus_master.bus_start();
        send(8'hf8, 1'b1);
        send(8'h40, 1'b1);
        i_qio_bus_master.bus_start();
        send(8'hf9, 1'b1);
        recv(1'b1, ID_MFR);
        recv(1'b1, ID_PART);
        recv(1'b0, ID_REV);
        i_qio_bus_master.bus_stop();
    endtask

    initial begin
        tick(20);
        sys_rst = 1'b0;
        check("lines after reset", ioEnN, LATCH_RST);
        check("sda after reset", {7'h0, sdaEnN}, 8'h01);
        tick(4);
        t_address();
        t_write_read();
        soft_reset(SWRST_CMD, 1, 1'b1, 8'h00);
        soft_reset(SWRST_CMD, 2, 1'b1, 8'h00);
        soft_reset(8'h05, 0, 1'b0, 8'h00);
        soft_reset(SWRST_CMD, 0, 1'b1, LATCH_RST);
        i_qio_bus_master.bus_start();
        send(8'h01, 1'b0);
        i_qio_bus_master.bus_stop();
        t_ident();
        print_verdict();
    end

    // whole run needs well under half of this span
    initial begin
        #1_000_000;
        mismatches++;
        print_verdict();
    end
endmodule
